/* ibt_consts.svh */
// Offsets, field positions, reset values and timing counts of the serial bus
`ifndef IBT_CONSTS_SVH
`define IBT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define IBT_OFF_CTRL 3'h0
`define IBT_OFF_DATA 3'h1
`define IBT_OFF_CFG 3'h2
`define IBT_OFF_IRQ_EN 3'h3
`define IBT_OFF_PRIO 3'h4
`define IBT_OFF_PRIO_HI 3'h5

// ----------------------------------------------------------------------
// Control register, read view
// ----------------------------------------------------------------------
`define IBT_CR_RX_BIT 7
`define IBT_CR_ATTN 6
`define IBT_CR_READY 5
`define IBT_CR_ARB 4
`define IBT_CR_START 3
`define IBT_CR_STOP 2
`define IBT_CR_MASTER 1

// ----------------------------------------------------------------------
// Control register, write view (commands)
// ----------------------------------------------------------------------
`define IBT_CW_CLR_XACT 7
`define IBT_CW_IDLE 6
`define IBT_CW_CLR_READY 5
`define IBT_CW_CLR_ARB 4
`define IBT_CW_CLR_START 3
`define IBT_CW_CLR_STOP 2
`define IBT_CW_XSTART 1
`define IBT_CW_XSTOP 0

// ----------------------------------------------------------------------
// Data, configuration and interrupt fields
// ----------------------------------------------------------------------
`define IBT_DR_TX_BIT 7
`define IBT_CFG_SLAVE_EN 7
`define IBT_CFG_MASTER_REQ 6
`define IBT_CFG_TIMER_RUN 4
`define IBT_CFG_SEL_HI 1
`define IBT_CFG_SEL_LO 0
`define IBT_CFG_WMASK 8'hd3
`define IBT_IRQ_TIMER_BIT 7
`define IBT_IRQ_SERIAL_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IBT_RST_CFG 8'h00
`define IBT_RST_IRQ 8'h00
`define IBT_RST_RDATA 8'h00

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define IBT_MC_CLKS 3'h6
`define IBT_MIN_MARK 10'h008
`define IBT_MIN_CNT0 10'h004
`define IBT_MIN_CNT1 10'h005
`define IBT_MIN_CNT2 10'h006
`define IBT_MIN_CNT3 10'h007
`define IBT_TIMER_TOP 10'h3ff

`endif

/* ibt_pkg.sv */
// Types shared by the serial bus interface and its bus timer
package ibt_pkg;
  typedef logic [2:0] ibt_addr_t;
  typedef logic [1:0] ibt_sel_t;
  typedef enum logic {IBT_BUS_FREE, IBT_IN_FRAME} ibt_phase_e;
endpackage : ibt_pkg

/* ibt_bus_timer.sv */
// Ten-bit bus timer for minimum times and stalled-bus detection
`timescale 1ns/100ps
`default_nettype none
`include "ibt_consts.svh"

module ibt_bus_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic enable,
  input wire logic frameActive,
  input wire logic restart,
  input wire ibt_pkg::ibt_sel_t presetSel,
  // Status
  output logic minDone,
  output logic carry
);
  import ibt_pkg::*;

  logic [2:0] mcCount;
  logic mcTick;
  logic [9:0] count;

  // ----------------------------------------------------------------------
  // Preload selection
  // ----------------------------------------------------------------------
  function automatic logic [9:0] preload(input ibt_sel_t sel);
    logic [9:0] cycles;
    cycles = `IBT_MIN_CNT0;
    unique case (sel)
      2'h0: cycles = `IBT_MIN_CNT0;
      2'h1: cycles = `IBT_MIN_CNT1;
      2'h2: cycles = `IBT_MIN_CNT2;
      2'h3: cycles = `IBT_MIN_CNT3;
    endcase
    return `IBT_MIN_MARK - cycles;
  endfunction : preload

  // ----------------------------------------------------------------------
  // Machine cycle divider
  // ----------------------------------------------------------------------
  assign mcTick = (mcCount == `IBT_MC_CLKS - 3'h1);

  always_ff @(posedge clk) begin
    if (!resetn || mcTick) begin
      mcCount <= 3'h0;
    end else begin
      mcCount <= mcCount + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || !enable || restart) begin
      count <= preload(presetSel);
    end else if (mcTick) begin
      if (frameActive) begin
        count <= count + 10'h001;
      end else if (!minDone) begin
        count <= count + 10'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      carry <= 1'b0;
    end else begin
      carry <= enable && frameActive && !restart && mcTick &&
               (count == `IBT_TIMER_TOP);
    end
  end

  // Low three bits cover the minimum times
  assign minDone = !enable || (|count[9:3]);

endmodule : ibt_bus_timer
`default_nettype wire

/* ibt_serial_if.sv */
// Single-bit two-wire serial bus interface with software pacing
// Operation
// - One-bit interface with framing checks, clock stretching and bus timeout.
// - Timer low bits enforce only the minimum low time, by stretching the clock in a frame.
// - Timer counts machine cycles, preload picked by two-bit prescale field.
// - Full ten-bit timer counts the maximum time between clock changes.
// - Each clock line transition restarts the timeout measurement.
// - Timer stops between frames once the minimum count is reached.
// - Carry comes 1020 to 1023 machine cycles after last clock change.
// - Carry resets the interface, releases clock and requests timer interrupt.
// - Timer runs and resets interface only while the run bit is set.
// - Timer interrupt enable at bit 7, with priority and high-priority bits.
// - Serial interrupt enable at bit 0, with settable priority.
// - Global and serial enable set: interrupt on attention.
// - Each rising clock edge samples data into the received bit.
// - Data register shows received bit on top; its read clears ready.
// - Attention is the OR of ready, arbitration lost, start and stop.
// - Ready set on each rising clock edge unless idle slave.
// - Ready cleared by clear command or any data register access.
// - After ready, clock held low in next low period within a frame until cleared.
// - Timer holds clock low in a frame long enough for minimum low time.
// - Data line pulled low only while transmit is active.
// - Start flag set on start when master or non-idle slave.
// - Written transmit bit reaches the data line only while clock low.
// - Timer preloaded with eight minus cycle count at each transition.
`timescale 1ns/100ps
`default_nettype none
`include "ibt_consts.svh"

module ibt_serial_if (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire ibt_pkg::ibt_addr_t regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Interrupt system
  input wire logic globalInterruptEnable,
  output logic serialIrq,
  output logic timerIrq,
  output logic [1:0] serialIrqLevel,
  output logic [1:0] timerIrqLevel,
  // Bus pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  import ibt_pkg::*;

  logic [1:0] pinIn;
  logic [1:0] syncA;
  logic [1:0] syncB;
  logic sclPrev;
  logic sdaPrev;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  ibt_phase_e phase;
  logic ifReset;
  logic timerCarry;
  logic minDone;
  logic [7:0] serial_config_reg;
  logic [7:0] irq_enable_reg_b;
  logic [7:0] irq_priority_reg_b;
  logic [7:0] irq_priority_high_reg_b;
  logic received_bit;
  logic bit_ready_flag;
  logic arbitration_lost_flag;
  logic start_seen_flag;
  logic stop_seen_flag;
  logic attention_flag;
  logic master;
  logic idle;
  logic idleSlave;
  logic xmitActive;
  logic transmit_bit;
  logic txOut;
  logic ctrlWr;
  logic dataWr;
  logic dataRd;
  logic arbEvent;
  logic next_sclOe;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input ibt_addr_t addr, input ibt_addr_t off);
    return addr == off;
  endfunction : hit

  assign ctrlWr = regWrite && hit(regAddr, `IBT_OFF_CTRL);
  assign dataWr = regWrite && hit(regAddr, `IBT_OFF_DATA);
  assign dataRd = regRead && hit(regAddr, `IBT_OFF_DATA);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  assign pinIn = {sdaIn, sclIn};

  for (genvar g = 0; g < 2; g++) begin : gSync
    always_ff @(posedge clk) begin
      if (!resetn) begin
        syncA[g] <= 1'b1;
        syncB[g] <= 1'b1;
      end else begin
        syncA[g] <= pinIn[g];
        syncB[g] <= syncA[g];
      end
    end
  end

  assign sclS = syncB[0];
  assign sdaS = syncB[1];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  assign sclRise = sclS && !sclPrev;
  assign sclFall = !sclS && sclPrev;
  assign startDet = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopDet = sclS && sclPrev && !sdaPrev && sdaS;

  // ----------------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || ifReset) begin
      phase <= IBT_BUS_FREE;
    end else begin
      unique case (phase)
        IBT_BUS_FREE: if (startDet) phase <= IBT_IN_FRAME;
        IBT_IN_FRAME: if (stopDet) phase <= IBT_BUS_FREE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus timer
  // ----------------------------------------------------------------------
  ibt_bus_timer uTimer (
    .clk(clk),
    .resetn(resetn),
    .enable(serial_config_reg[`IBT_CFG_TIMER_RUN]),
    .frameActive(phase == IBT_IN_FRAME),
    .restart(sclRise || sclFall || startDet || stopDet),
    .presetSel({serial_config_reg[`IBT_CFG_SEL_HI],
                serial_config_reg[`IBT_CFG_SEL_LO]}),
    .minDone(minDone),
    .carry(timerCarry)
  );

  assign ifReset = timerCarry;

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      serial_config_reg <= `IBT_RST_CFG;
    end else if (regWrite && hit(regAddr, `IBT_OFF_CFG)) begin
      serial_config_reg <= regWdata & `IBT_CFG_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_enable_reg_b <= `IBT_RST_IRQ;
      irq_priority_reg_b <= `IBT_RST_IRQ;
      irq_priority_high_reg_b <= `IBT_RST_IRQ;
    end else if (regWrite) begin
      if (hit(regAddr, `IBT_OFF_IRQ_EN)) begin
        irq_enable_reg_b <= regWdata;
      end
      if (hit(regAddr, `IBT_OFF_PRIO)) begin
        irq_priority_reg_b <= regWdata;
      end
      if (hit(regAddr, `IBT_OFF_PRIO_HI)) begin
        irq_priority_high_reg_b <= regWdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Received bit and status flags
  // ----------------------------------------------------------------------
  assign idleSlave = idle && !master;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      received_bit <= 1'b0;
    end else if (sclRise) begin
      received_bit <= sdaS;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || ifReset) begin
      idle <= 1'b0;
    end else if (startDet) begin
      idle <= 1'b0;
    end else if (ctrlWr && regWdata[`IBT_CW_IDLE]) begin
      idle <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || ifReset) begin
      bit_ready_flag <= 1'b0;
    end else if (sclRise && !idleSlave) begin
      bit_ready_flag <= 1'b1;
    end else if ((ctrlWr && regWdata[`IBT_CW_CLR_READY]) ||
                 dataWr || dataRd) begin
      bit_ready_flag <= 1'b0;
    end
  end

  assign arbEvent = sclRise && xmitActive && txOut && !sdaS;

  always_ff @(posedge clk) begin
    if (!resetn || ifReset) begin
      arbitration_lost_flag <= 1'b0;
    end else if (arbEvent) begin
      arbitration_lost_flag <= 1'b1;
    end else if (ctrlWr && regWdata[`IBT_CW_CLR_ARB]) begin
      arbitration_lost_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || ifReset) begin
      start_seen_flag <= 1'b0;
    end else if (startDet && (master || !idle)) begin
      start_seen_flag <= 1'b1;
    end else if (ctrlWr && regWdata[`IBT_CW_CLR_START]) begin
      start_seen_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || ifReset) begin
      stop_seen_flag <= 1'b0;
    end else if (stopDet && (master || !idle)) begin
      stop_seen_flag <= 1'b1;
    end else if (ctrlWr && regWdata[`IBT_CW_CLR_STOP]) begin
      stop_seen_flag <= 1'b0;
    end
  end

  assign attention_flag = bit_ready_flag || arbitration_lost_flag ||
                          start_seen_flag || stop_seen_flag;

  // ----------------------------------------------------------------------
  // Mastership
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || ifReset) begin
      master <= 1'b0;
    end else if (arbEvent) begin
      master <= 1'b0;
    end else if (ctrlWr && regWdata[`IBT_CW_XSTOP] &&
                 !serial_config_reg[`IBT_CFG_MASTER_REQ]) begin
      master <= 1'b0;
    end else if (serial_config_reg[`IBT_CFG_MASTER_REQ] &&
                 phase == IBT_BUS_FREE && !startDet) begin
      master <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || ifReset) begin
      xmitActive <= 1'b0;
    end else if (arbEvent) begin
      xmitActive <= 1'b0;
    end else if (dataWr || (ctrlWr && (regWdata[`IBT_CW_XSTART] ||
                                       regWdata[`IBT_CW_XSTOP]))) begin
      xmitActive <= 1'b1;
    end else if (dataRd || (ctrlWr && regWdata[`IBT_CW_CLR_XACT])) begin
      xmitActive <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      transmit_bit <= 1'b1;
    end else if (dataWr) begin
      transmit_bit <= regWdata[`IBT_DR_TX_BIT];
    end else if (ctrlWr && regWdata[`IBT_CW_XSTART]) begin
      transmit_bit <= 1'b1;
    end else if (ctrlWr && regWdata[`IBT_CW_XSTOP]) begin
      transmit_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      txOut <= 1'b1;
    end else if (!sclS) begin
      txOut <= transmit_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || ifReset) begin
      sdaOe <= 1'b0;
    end else begin
      sdaOe <= xmitActive && !arbEvent && !txOut;
    end
  end

  // ----------------------------------------------------------------------
  // Clock stretching
  // ----------------------------------------------------------------------
  assign next_sclOe = !sclS && phase == IBT_IN_FRAME &&
                      (attention_flag || !minDone);

  always_ff @(posedge clk) begin
    if (!resetn || ifReset) begin
      sclOe <= 1'b0;
    end else begin
      sclOe <= next_sclOe;
    end
  end

  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

  // ----------------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      serialIrq <= 1'b0;
      timerIrq <= 1'b0;
      serialIrqLevel <= 2'h0;
      timerIrqLevel <= 2'h0;
    end else begin
      serialIrq <= globalInterruptEnable && attention_flag &&
                   irq_enable_reg_b[`IBT_IRQ_SERIAL_BIT];
      timerIrq <= timerCarry &&
                  irq_enable_reg_b[`IBT_IRQ_TIMER_BIT];
      serialIrqLevel <= {irq_priority_high_reg_b[`IBT_IRQ_SERIAL_BIT],
                         irq_priority_reg_b[`IBT_IRQ_SERIAL_BIT]};
      timerIrqLevel <= {irq_priority_high_reg_b[`IBT_IRQ_TIMER_BIT],
                        irq_priority_reg_b[`IBT_IRQ_TIMER_BIT]};
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRdata <= `IBT_RST_RDATA;
    end else if (regRead) begin
      regRdata <= 8'h00;
      if (hit(regAddr, `IBT_OFF_CTRL)) begin
        regRdata[`IBT_CR_RX_BIT] <= received_bit;
        regRdata[`IBT_CR_ATTN] <= attention_flag;
        regRdata[`IBT_CR_READY] <= bit_ready_flag;
        regRdata[`IBT_CR_ARB] <= arbitration_lost_flag;
        regRdata[`IBT_CR_START] <= start_seen_flag;
        regRdata[`IBT_CR_STOP] <= stop_seen_flag;
        regRdata[`IBT_CR_MASTER] <= master;
      end
      if (hit(regAddr, `IBT_OFF_DATA)) begin
        regRdata[`IBT_DR_TX_BIT] <= received_bit;
      end
      if (hit(regAddr, `IBT_OFF_CFG)) begin
        regRdata <= serial_config_reg;
      end
      if (hit(regAddr, `IBT_OFF_IRQ_EN)) begin
        regRdata <= irq_enable_reg_b;
      end
      if (hit(regAddr, `IBT_OFF_PRIO)) begin
        regRdata <= irq_priority_reg_b;
      end
      if (hit(regAddr, `IBT_OFF_PRIO_HI)) begin
        regRdata <= irq_priority_high_reg_b;
      end
    end
  end

endmodule : ibt_serial_if
`default_nettype wire

/* ibt_serial_if_checker.sv */
// Port-level assertions for the serial bus interface
`timescale 1ns/100ps
`default_nettype none

module ibt_serial_if_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire ibt_pkg::ibt_addr_t regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  // Interrupt system
  input wire logic globalInterruptEnable,
  input wire logic serialIrq,
  input wire logic timerIrq,
  input wire logic [1:0] serialIrqLevel,
  input wire logic [1:0] timerIrqLevel,
  // Bus pins
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  import ibt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------
  // Assertions
  // ----------------
  a_data_low_zero: assert property (
    regRead && regAddr == 3'h1 |=> regRdata[6:0] == 7'h00)
    else $error("data read low bits set");
  a_attn_is_or: assert property (
    regRead && regAddr == 3'h0 |=> regRdata[6] == (|regRdata[5:2]))
    else $error("attention differs from flag OR");
  a_unmapped_zero: assert property (
    regRead && regAddr[2:1] == 2'b11 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_ready_clr_data: assert property (
    regRead && regAddr == 3'h1 ##2 regRead && regAddr == 3'h0
    |=> !regRdata[5]) else $error("ready kept after data read");
  a_irq_needs_global: assert property (
    serialIrq |-> $past(globalInterruptEnable))
    else $error("serial irq without global enable");
  a_tirq_one_pulse: assert property (timerIrq |=> !timerIrq)
    else $error("timer irq longer than one cycle");
  a_carry_release: assert property (
    timerIrq |-> ##[1:2] (!sclOe && !sdaOe))
    else $error("lines held after timeout");
  a_stretch_low: assert property (
    $rose(sclOe) |-> $past(sclIn, 2) == 1'b0)
    else $error("clock stretch began with clock high");
  a_tx_clock_low: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data driven while clock high");
  a_open_drain: assert property (!sclOut && !sdaOut)
    else $error("pin driven high");
  // ----------------
  // Coverage
  // ----------------
  c_timeout: cover property (timerIrq);
  c_stretch: cover property ($rose(sclOe));
  c_serial_irq: cover property ($rose(serialIrq));
endmodule : ibt_serial_if_checker

bind ibt_serial_if ibt_serial_if_checker u_chk (.clk(clk), .resetn(resetn),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata),
  .globalInterruptEnable(globalInterruptEnable), .serialIrq(serialIrq),
  .timerIrq(timerIrq), .serialIrqLevel(serialIrqLevel),
  .timerIrqLevel(timerIrqLevel), .sclIn(sclIn), .sclOut(sclOut),
  .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
`default_nettype wire

/* ibt_bus_partner.sv */
// Other party on the two-wire bus, open drain with pull-ups
`timescale 1ns/100ps
`default_nettype none

module ibt_bus_partner (
  // Clock
  input wire logic clk,
  // Device pulls
  input wire logic sclOe,
  input wire logic sdaOe,
  // Wire levels
  output logic sclLine,
  output logic sdaLine
);
  logic pullScl = 1'b0;
  logic pullSda = 1'b0;
  // Released lines float high
  assign sclLine = !(pullScl || sclOe);
  assign sdaLine = !(pullSda || sdaOe);
  // Data change, spaced from the last clock change
  task automatic set_data(input logic b);
    repeat (10) @(posedge clk);
    pullSda <= !b;
  endtask : set_data
  // Clock change, waits out a stretch
  task automatic set_clock(input logic high, output logic ok);
    int n;
    repeat (10) @(posedge clk);
    pullScl <= !high;
    n = 0;
    while (sclLine !== high && n < 300) begin
      @(posedge clk);
      n++;
    end
    ok = (sclLine === high);
  endtask : set_clock
endmodule : ibt_bus_partner
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the serial bus interface
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import ibt_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  ibt_addr_t regAddr;
  logic [7:0] regWdata;
  logic regWrite;
  logic regRead;
  logic globalInterruptEnable;
  logic [7:0] regRdata;
  logic serialIrq, timerIrq, sclLine, sdaLine, sclOut, sclOe, sdaOut, sdaOe;
  logic [1:0] serialIrqLevel, timerIrqLevel;
  int failCount = 0;
  int samplesChecked = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  ibt_serial_if dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .globalInterruptEnable(globalInterruptEnable),
    .serialIrq(serialIrq), .timerIrq(timerIrq),
    .serialIrqLevel(serialIrqLevel), .timerIrqLevel(timerIrqLevel),
    .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe));
  ibt_bus_partner bus (.clk(clk), .sclOe(sclOe), .sdaOe(sdaOe),
    .sclLine(sclLine), .sdaLine(sdaLine));

  // ----------------
  // Helpers
  // ----------------
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic reg_wr(input ibt_addr_t a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input ibt_addr_t a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask : reg_rd
  task automatic clk_to(input logic v);
    logic ok;
    bus.set_clock(v, ok);
    chk1(ok, 1'b1);
    if (ok !== 1'b1) end_sim();
  endtask : clk_to
  task automatic count_irq(input int c, output int n);
    n = 0;
    repeat (c) begin
      @(posedge clk);
      #1;
      if (timerIrq === 1'b1) n++;
    end
  endtask : count_irq

  // ----------------
  // Scenarios
  // ----------------
  task automatic s_regs();
    logic [7:0] d;
    reg_rd(3'h2, d);
    chk8(d, 8'h00);
    reg_wr(3'h2, 8'hff);
    reg_rd(3'h2, d);
    chk8(d, 8'hd3);
    reg_wr(3'h2, 8'h00);
    reg_wr(3'h3, 8'h81);
    reg_rd(3'h3, d);
    chk8(d, 8'h81);
    reg_wr(3'h6, 8'hff);
    reg_rd(3'h6, d);
    chk8(d, 8'h00);
    reg_wr(3'h4, 8'h81);
    reg_wr(3'h5, 8'h01);
    idle(2);
    chk8({4'h0, serialIrqLevel, timerIrqLevel}, 8'h0d);
    reg_wr(3'h3, 8'h00);
  endtask : s_regs
  task automatic s_receive();
    logic [7:0] d;
    reg_wr(3'h2, 8'h40);
    reg_rd(3'h0, d);
    chk1(d[1], 1'b1);
    bus.set_data(1'b0);
    clk_to(1'b0);
    idle(10);
    reg_rd(3'h0, d);
    chk8(d & 8'h7c, 8'h48);
    reg_wr(3'h0, 8'h08);
    for (int i = 0; i < 2; i++) begin
      bus.set_data(i == 0);
      clk_to(1'b1);
      idle(20);
      clk_to(1'b0);
      idle(10);
      chk1(sclOe, 1'b1);
      reg_rd(3'h0, d);
      chk8(d & 8'he0, {(i == 0), 7'h60});
      reg_rd(3'h0, d);
      chk1(d[5], 1'b1);
      if (i == 0) begin
        reg_rd(3'h1, d);
        chk8(d, 8'h80);
      end else begin
        reg_wr(3'h0, 8'h20);
      end
      reg_rd(3'h0, d);
      chk1(d[5], 1'b0);
      idle(5);
      chk1(sclOe, 1'b0);
    end
  endtask : s_receive
  task automatic s_transmit();
    logic [7:0] d;
    reg_wr(3'h2, 8'h50);
    bus.set_data(1'b1);
    clk_to(1'b1);
    idle(5);
    reg_wr(3'h1, 8'h00);
    idle(10);
    chk1(sdaOe, 1'b0);
    clk_to(1'b0);
    idle(10);
    chk1(sdaOe, 1'b1);
    chk1(sclOe, 1'b1);
    clk_to(1'b1);
    clk_to(1'b0);
    reg_rd(3'h1, d);
    chk8(d, 8'h00);
    idle(5);
    chk1(sdaOe, 1'b0);
    reg_wr(3'h0, 8'h01);
    idle(5);
    chk1(sdaOe, 1'b1);
    reg_wr(3'h0, 8'h80);
    idle(5);
    chk1(sdaOe, 1'b0);
    reg_wr(3'h2, 8'h40);
  endtask : s_transmit
  task automatic s_irq();
    logic [7:0] d;
    reg_wr(3'h3, 8'h01);
    globalInterruptEnable <= 1'b1;
    idle(5);
    chk1(serialIrq, 1'b0);
    bus.set_data(1'b0);
    clk_to(1'b1);
    bus.set_data(1'b1);
    idle(10);
    chk1(serialIrq, 1'b1);
    globalInterruptEnable <= 1'b0;
    idle(3);
    chk1(serialIrq, 1'b0);
    globalInterruptEnable <= 1'b1;
    reg_rd(3'h0, d);
    chk8(d & 8'h7c, 8'h64);
    reg_wr(3'h0, 8'h24);
    idle(3);
    chk1(serialIrq, 1'b0);
    reg_wr(3'h3, 8'h80);
  endtask : s_irq
  task automatic s_timeout();
    logic [7:0] d;
    int n;
    bus.set_data(1'b0);
    clk_to(1'b0);
    reg_wr(3'h0, 8'h08);
    count_irq(6300, n);
    chk1(n == 0, 1'b1);
    reg_wr(3'h2, 8'h50);
    idle(3000);
    clk_to(1'b1);
    reg_wr(3'h0, 8'h20);
    clk_to(1'b0);
    n = 0;
    while (timerIrq !== 1'b1 && n < 6400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk1(n >= 6110 && n <= 6150, 1'b1);
    idle(3);
    chk1(sclOe, 1'b0);
    reg_rd(3'h0, d);
    chk8(d & 8'h7c, 8'h00);
    bus.set_data(1'b1);
    clk_to(1'b1);
    count_irq(6300, n);
    chk1(n == 0, 1'b1);
  endtask : s_timeout

  initial begin
    regAddr <= 3'h0;
    regWdata <= 8'h00;
    regWrite <= 1'b0;
    regRead <= 1'b0;
    globalInterruptEnable <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    s_regs();
    s_receive();
    s_transmit();
    s_irq();
    s_timeout();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
